// file: hdl/usb_err_ep_map.vh
`ifndef USB_ERR_EP_MAP_VH
`define USB_ERR_EP_MAP_VH
`define ADDR_ERROR_FLAGS_HOST   6'h00
`define ADDR_ERROR_MASK_DEVICE  6'h01
`define ADDR_ERROR_MASK_HOST    6'h02
`define ADDR_IRQ_STATUS         6'h03
`define ADDR_IRQ_MASK           6'h04
`define ADDR_MODE               6'h05
`define ADDR_EP_BASE            6'h10
`define BIT_STUFF_ERR           7
`define BIT_RAM_ACCESS_ERR      6
`define BIT_BUFFER_OVERRUN      5
`define BIT_TURNAROUND_TIMEOUT  4
`define BIT_PARTIAL_BYTE        3
`define BIT_DATA_CHECK_FAIL     2
`define BIT_FRAME_END_ERR       1
`define BIT_TOKEN_CHECK_FAIL    1
`define BIT_PACKET_ID_FAIL      0
`define BIT_SLOW_DIRECT_LINK    7
`define BIT_NAK_RETRY_OFF       6
`define BIT_SETUP_BLOCK         4
`define BIT_EP_RECEIVE_ON       3
`define BIT_EP_TRANSMIT_ON      2
`define BIT_EP_STALLED          1
`define BIT_EP_HANDSHAKE_ON     0
`define RST_FLAGS               8'h00
`define RST_MASK                8'h00
`define RST_EP                  8'h00
`define EP0_ONLY_MASK           8'hC0
`define EP_RW_MASK              8'h1F
`endif

// file: hdl/ep_ctrl_reg.v
`timescale 1ns/100ps
`include "usb_err_ep_map.vh"
module ep_ctrl_reg #(
    parameter IS_EP0 = 0
) (
    input  wire       mclk,
    input  wire       rst_b,
    input  wire       ce,
    input  wire       wr,
    input  wire       host_mode,
    input  wire [7:0] wdata,
    output wire [7:0] value
);
    reg  [7:0] ctrl_r;
    wire [7:0] keep_mask;

    assign keep_mask = (IS_EP0 != 0) ? (`EP0_ONLY_MASK | `EP_RW_MASK) : `EP_RW_MASK;

    always @(posedge mclk) begin
        if (!rst_b) begin
            ctrl_r <= `RST_EP;
        end else if (ce && wr) begin
            ctrl_r <= wdata & keep_mask;
        end
    end

    // Endpoint-0 only bits are visible in host mode only.
    assign value = host_mode ? ctrl_r : (ctrl_r & `EP_RW_MASK);
endmodule // ep_ctrl_reg

// file: hdl/usb_error_and_endpoint_regs.v
`timescale 1ns/100ps
`include "usb_err_ep_map.vh"
module usb_error_and_endpoint_regs #(
    parameter NUM_EP = 16
) (
    input  wire        mclk,
    input  wire        rst_b,
    input  wire        ce,
    input  wire [5:0]  addr,
    input  wire [15:0] wdata,
    input  wire        wr_stb,
    input  wire        rd_stb,
    output reg  [15:0] rdata,
    input  wire [7:0]  err_event,
    input  wire        token_check_fail_evt,
    input  wire [3:0]  rx_ep,
    input  wire [9:0]  rx_byte_count,
    input  wire [9:0]  rx_desc_limit,
    input  wire        rx_count_valid,
    input  wire [3:0]  tx_ep,
    output reg  [9:0]  rx_trunc_count,
    output reg  [15:0] ep_rx_allow,
    output reg  [15:0] ep_tx_allow,
    output reg  [15:0] ep_setup_allow,
    output reg  [15:0] ep_stalled,
    output reg  [15:0] ep_handshake_on,
    output reg         nak_retry_on,
    output reg         slow_direct_link,
    output reg         host_mode,
    output reg         rx_allowed,
    output reg         tx_allowed,
    output reg         summary_error_irq,
    output reg         irq
);
    reg  [7:0]  error_flags_host_r;
    reg  [7:0]  error_flags_host_nxt;
    reg  [7:0]  token_flag_r;
    reg  [7:0]  error_mask_device_r;
    reg  [7:0]  error_mask_host_r;
    reg  [1:0]  irq_status_r;
    reg  [1:0]  irq_status_nxt;
    reg  [1:0]  irq_mask_r;
    wire [7:0]  ev_all;
    wire [7:0]  active_flags;
    wire [7:0]  active_mask;
    wire        overrun_evt;
    wire        err_any;
    wire [7:0]  ep_val [0:NUM_EP-1];
    wire        wr_flags;
    wire        wr_ep;
    integer     i;
    integer     j;
    integer     k;
    reg  [7:0]  token_flag_nxt;
    reg         token_bit_nxt;
    reg  [15:0] rdata_nxt;
    wire        wr_mask_dev;
    wire        wr_mask_host;
    wire        wr_irq_mask;
    wire        wr_irq_status;
    wire        wr_mode;
    localparam [5:0] EP_BASE = `ADDR_EP_BASE;

    assign wr_flags    = ce && wr_stb && (addr == `ADDR_ERROR_FLAGS_HOST);
    assign wr_ep         = (addr[5:4] == EP_BASE[5:4]);
    assign wr_mask_dev   = ce && wr_stb && (addr == `ADDR_ERROR_MASK_DEVICE);
    assign wr_mask_host  = ce && wr_stb && (addr == `ADDR_ERROR_MASK_HOST);
    assign wr_irq_mask   = ce && wr_stb && (addr == `ADDR_IRQ_MASK);
    assign wr_irq_status = ce && wr_stb && (addr == `ADDR_IRQ_STATUS);
    assign wr_mode       = ce && wr_stb && (addr == `ADDR_MODE);
    assign overrun_evt = rx_count_valid && (rx_byte_count > rx_desc_limit);
    assign ev_all      = err_event | ({7'h00, overrun_evt} << `BIT_BUFFER_OVERRUN);

    // In device mode bit 1 carries the token check failure instead of frame end.
    assign active_flags = host_mode ? error_flags_host_r : token_flag_r;
    assign active_mask  = host_mode ? error_mask_host_r : error_mask_device_r;
    assign err_any      = |(active_flags & active_mask);

    always @* begin
        error_flags_host_nxt = error_flags_host_r;
        if (wr_flags) begin
            error_flags_host_nxt = error_flags_host_nxt & ~wdata[7:0];
        end
        error_flags_host_nxt = error_flags_host_nxt | ev_all;
    end

    // Interrupt status: bit 0 follows the summary error, bit 1 the overrun; set wins over clear.
    always @* begin
        irq_status_nxt = irq_status_r;
        if (wr_irq_status) begin
            irq_status_nxt = irq_status_nxt & ~wdata[1:0];
        end
        irq_status_nxt = irq_status_nxt | {overrun_evt, err_any};
    end

    // Bit 1 of the device view is a sticky flag of its own; a new event beats a clear.
    always @* begin
        token_flag_nxt = error_flags_host_nxt & ~(8'h01 << `BIT_FRAME_END_ERR);
        token_bit_nxt  = token_flag_r[`BIT_TOKEN_CHECK_FAIL];
        if (wr_flags && wdata[`BIT_TOKEN_CHECK_FAIL]) begin
            token_bit_nxt = 1'b0;
        end
        if (token_check_fail_evt) begin
            token_bit_nxt = 1'b1;
        end
        token_flag_nxt[`BIT_TOKEN_CHECK_FAIL] = token_bit_nxt;
    end

    // Error flag stores.
    always @(posedge mclk) begin
        if (!rst_b) begin
            error_flags_host_r <= `RST_FLAGS;
            token_flag_r       <= `RST_FLAGS;
        end else if (ce) begin
            error_flags_host_r <= error_flags_host_nxt;
            token_flag_r       <= token_flag_nxt;
        end
    end

    // Summary error and interrupt outputs.
    always @(posedge mclk) begin
        if (!rst_b) begin
            irq_status_r      <= 2'h0;
            summary_error_irq <= 1'b0;
            irq               <= 1'b0;
        end else if (ce) begin
            irq_status_r      <= irq_status_nxt;
            summary_error_irq <= err_any;
            irq               <= |(irq_status_nxt & irq_mask_r);
        end
    end

    // Truncated byte count of the last received packet.
    always @(posedge mclk) begin
        if (!rst_b) begin
            rx_trunc_count <= 10'h000;
        end else if (ce && rx_count_valid) begin
            rx_trunc_count <= overrun_evt ? rx_desc_limit : rx_byte_count;
        end
    end

    // Device-mode error mask.
    always @(posedge mclk) begin
        if (!rst_b) begin
            error_mask_device_r <= `RST_MASK;
        end else if (wr_mask_dev) begin
            error_mask_device_r <= wdata[7:0];
        end
    end

    // Host-mode error mask.
    always @(posedge mclk) begin
        if (!rst_b) begin
            error_mask_host_r <= `RST_MASK;
        end else if (wr_mask_host) begin
            error_mask_host_r <= wdata[7:0];
        end
    end

    // Interrupt mask.
    always @(posedge mclk) begin
        if (!rst_b) begin
            irq_mask_r <= 2'h0;
        end else if (wr_irq_mask) begin
            irq_mask_r <= wdata[1:0];
        end
    end

    // Mode register, bit 0 selects host mode.
    always @(posedge mclk) begin
        if (!rst_b) begin
            host_mode <= 1'b0;
        end else if (wr_mode) begin
            host_mode <= wdata[0];
        end
    end

    // Read data stand for one cycle after a read strobe with ce high, are zero after other ce-high cycles, and hold while ce is low.
    always @* begin
        rdata_nxt = 16'h0000;
        if (rd_stb) begin
            if (wr_ep) begin
                rdata_nxt = {8'h00, ep_val[addr[3:0]]};
            end else begin
                case (addr)
                    `ADDR_ERROR_FLAGS_HOST:  rdata_nxt = {8'h00, active_flags};
                    `ADDR_ERROR_MASK_DEVICE: rdata_nxt = {8'h00, error_mask_device_r};
                    `ADDR_ERROR_MASK_HOST:   rdata_nxt = {8'h00, error_mask_host_r};
                    `ADDR_IRQ_STATUS:        rdata_nxt = {14'h0000, irq_status_r};
                    `ADDR_IRQ_MASK:          rdata_nxt = {14'h0000, irq_mask_r};
                    `ADDR_MODE:              rdata_nxt = {15'h0000, host_mode};
                    default:                 rdata_nxt = 16'h0000;
                endcase
            end
        end
    end

    always @(posedge mclk) begin
        if (!rst_b) begin
            rdata <= 16'h0000;
        end else if (ce) begin
            rdata <= rdata_nxt;
        end
    end

    // One control register per endpoint; only endpoint 0 keeps bits 7 and 6.
    genvar g;
    generate
        for (g = 0; g < NUM_EP; g = g + 1) begin : ep
            ep_ctrl_reg #(
                .IS_EP0 (g == 0)
            ) u_ep (
                .mclk      (mclk),
                .rst_b     (rst_b),
                .ce        (ce),
                .wr        (wr_stb && wr_ep && (addr[3:0] == g)),
                .host_mode (host_mode),
                .wdata     (wdata[7:0]),
                .value     (ep_val[g])
            );
        end
    endgenerate

    // Per-endpoint transfer enables.
    always @(posedge mclk) begin
        if (!rst_b) begin
            ep_rx_allow <= 16'h0000;
            ep_tx_allow <= 16'h0000;
        end else if (ce) begin
            for (i = 0; i < NUM_EP; i = i + 1) begin
                ep_rx_allow[i] <= ep_val[i][`BIT_EP_RECEIVE_ON];
                ep_tx_allow[i] <= ep_val[i][`BIT_EP_TRANSMIT_ON];
            end
        end
    end

    // SETUP acceptance needs both directions enabled and the block bit clear.
    always @(posedge mclk) begin
        if (!rst_b) begin
            ep_setup_allow <= 16'h0000;
        end else if (ce) begin
            for (j = 0; j < NUM_EP; j = j + 1) begin
                ep_setup_allow[j] <= ep_val[j][`BIT_EP_RECEIVE_ON] && ep_val[j][`BIT_EP_TRANSMIT_ON] &&
                                     !ep_val[j][`BIT_SETUP_BLOCK];
            end
        end
    end

    // Stall and handshake bits as seen by the transfer engine.
    always @(posedge mclk) begin
        if (!rst_b) begin
            ep_stalled      <= 16'h0000;
            ep_handshake_on <= 16'h0000;
        end else if (ce) begin
            for (k = 0; k < NUM_EP; k = k + 1) begin
                ep_stalled[k]      <= ep_val[k][`BIT_EP_STALLED];
                ep_handshake_on[k] <= ep_val[k][`BIT_EP_HANDSHAKE_ON];
            end
        end
    end

    // Endpoint 0 host-only controls.
    always @(posedge mclk) begin
        if (!rst_b) begin
            nak_retry_on     <= 1'b0;
            slow_direct_link <= 1'b0;
        end else if (ce) begin
            nak_retry_on     <= host_mode && !ep_val[0][`BIT_NAK_RETRY_OFF];
            slow_direct_link <= ep_val[0][`BIT_SLOW_DIRECT_LINK];
        end
    end

    // Enables of the endpoints that the transfer engine is asking about.
    always @(posedge mclk) begin
        if (!rst_b) begin
            rx_allowed <= 1'b0;
            tx_allowed <= 1'b0;
        end else if (ce) begin
            rx_allowed <= ep_val[rx_ep][`BIT_EP_RECEIVE_ON];
            tx_allowed <= ep_val[tx_ep][`BIT_EP_TRANSMIT_ON];
        end
    end
endmodule // usb_error_and_endpoint_regs

// file: tb/usb_regs_monitor.sv
`timescale 1ns/100ps
module usb_regs_monitor (
    input wire logic        mclk,
    input wire logic        rst_b,
    input wire logic        wr_stb,
    input wire logic        rd_stb,
    input wire logic        rx_count_valid,
    input wire logic [3:0]  rx_ep,
    input wire logic [3:0]  tx_ep,
    input wire logic [9:0]  rx_byte_count,
    input wire logic [9:0]  rx_desc_limit,
    input wire logic [9:0]  rx_trunc_count,
    input wire logic [15:0] rdata,
    input wire logic [15:0] ep_rx_allow,
    input wire logic [15:0] ep_tx_allow,
    input wire logic [15:0] ep_setup_allow,
    input wire logic [15:0] ep_stalled,
    input wire logic [15:0] ep_handshake_on,
    input wire logic        nak_retry_on,
    input wire logic        host_mode,
    input wire logic        rx_allowed,
    input wire logic        tx_allowed
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    sequence no_read_s; !rd_stb; endsequence
    sequence packet_s; rx_count_valid; endsequence
    AST_RDATA_IDLE: assert property (no_read_s |=> rdata == 16'h0000) else $error("rdata not idle");
    AST_UPPER_ZERO: assert property (rdata[15:8] == 8'h00) else $error("upper byte set");
    AST_TRUNC: assert property (packet_s |=> rx_trunc_count ==
        ($past(rx_byte_count) > $past(rx_desc_limit) ? $past(rx_desc_limit) : $past(rx_byte_count)))
        else $error("truncated count wrong");
    AST_SETUP_GATE: assert property ((ep_setup_allow & ~(ep_rx_allow & ep_tx_allow)) == 16'h0000)
        else $error("setup allowed without both enables");
    AST_RX_GATE: assert property (rx_allowed == ep_rx_allow[$past(rx_ep)]) else $error("rx gate");
    AST_TX_GATE: assert property (tx_allowed == ep_tx_allow[$past(tx_ep)]) else $error("tx gate");
    AST_NAK_HOST: assert property (nak_retry_on && $stable(host_mode) |-> host_mode) else $error("retry");
    AST_EP_WRITE: assert property (!$stable({ep_stalled, ep_handshake_on}) |-> $past(wr_stb, 2))
        else $error("endpoint bits changed without write");
endmodule // usb_regs_monitor

bind usb_error_and_endpoint_regs usb_regs_monitor usb_regs_monitor_inst (.mclk, .rst_b, .wr_stb, .rd_stb,
    .rx_count_valid, .rx_ep, .tx_ep, .rx_byte_count, .rx_desc_limit, .rx_trunc_count, .rdata, .ep_rx_allow,
    .ep_tx_allow, .ep_setup_allow, .ep_stalled, .ep_handshake_on, .nak_retry_on, .host_mode, .rx_allowed,
    .tx_allowed);

// file: tb/usb_peer_model.sv
`timescale 1ns/100ps
module usb_peer_model (
    input  wire logic mclk,
    output logic [7:0] err_event,
    output logic       token_check_fail_evt,
    output logic [3:0] rx_ep,
    output logic [9:0] rx_byte_count,
    output logic [9:0] rx_desc_limit,
    output logic       rx_count_valid
);
    initial begin
        {err_event, token_check_fail_evt, rx_count_valid} = '0;
        {rx_ep, rx_byte_count, rx_desc_limit} = '0;
    end
    task errs(input logic [7:0] e, input logic t);
        @(posedge mclk);
        err_event <= e;
        token_check_fail_evt <= t;
        @(posedge mclk);
        err_event <= 8'h00;
        token_check_fail_evt <= 1'b0;
        #1;
    endtask
    // Counts are inverted after a packet so stale values never look live.
    task pkt(input logic [3:0] ep, input logic [9:0] n, lim);
        @(posedge mclk);
        rx_ep <= ep;
        rx_byte_count <= n;
        rx_desc_limit <= lim;
        rx_count_valid <= 1'b1;
        @(posedge mclk);
        rx_count_valid <= 1'b0;
        rx_byte_count <= ~n;
        rx_desc_limit <= ~lim;
    endtask
endmodule // usb_peer_model

// file: tb/tb.sv
`timescale 1ns/100ps
`include "usb_err_ep_map.vh"
module tb;
    typedef struct {logic [5:0] a; logic [15:0] d; logic [15:0] q;} row_t;
    logic        mclk = 1'b0;
    logic        rst_b = 1'b0;
    logic [5:0]  addr = 6'h00;
    logic [15:0] wdata = 16'h0000;
    logic        wr_stb = 1'b0;
    logic        rd_stb = 1'b0;
    logic [3:0]  tx_ep = 4'h0;
    logic        ce = 1'b1;
    wire  [15:0] rdata, ep_rx_allow, ep_tx_allow, ep_setup_allow, ep_stalled, ep_handshake_on;
    wire  [9:0]  rx_trunc_count, rx_byte_count, rx_desc_limit;
    wire  [7:0]  err_event;
    wire  [3:0]  rx_ep;
    wire         token_check_fail_evt, rx_count_valid, nak_retry_on, slow_direct_link, host_mode;
    wire         rx_allowed, tx_allowed, summary_error_irq, irq;
    int          err_total = 0;
    int          n_checks = 0;
    row_t        rows [6] = '{'{6'h11, 16'hFFFF, 16'h001F}, '{6'h1F, 16'h00D5, 16'h0015},
        '{6'h10, 16'h00C3, 16'h0003}, '{6'h01, 16'hFFFF, 16'h00FF}, '{6'h02, 16'h1234, 16'h0034},
        '{6'h3F, 16'hFFFF, 16'h0000}};
    always #2.5 mclk = ~mclk;
    usb_error_and_endpoint_regs usb_error_and_endpoint_regs_inst (.mclk, .rst_b, .ce, .addr, .wdata,
        .wr_stb, .rd_stb, .rdata, .err_event, .token_check_fail_evt, .rx_ep, .rx_byte_count, .rx_desc_limit,
        .rx_count_valid, .tx_ep, .rx_trunc_count, .ep_rx_allow, .ep_tx_allow, .ep_setup_allow, .ep_stalled,
        .ep_handshake_on, .nak_retry_on, .slow_direct_link, .host_mode, .rx_allowed, .tx_allowed,
        .summary_error_irq, .irq);
    usb_peer_model usb_peer_model_inst (.mclk, .err_event, .token_check_fail_evt, .rx_ep, .rx_byte_count,
        .rx_desc_limit, .rx_count_valid);
    task chk(input string n, input logic [15:0] e, g);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task acc(input bit w, input logic [5:0] a, input logic [15:0] d, e);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr_stb <= w;
        rd_stb <= !w;
        @(posedge mclk);
        wr_stb <= 1'b0;
        rd_stb <= 1'b0;
        #1;
        if (!w) chk("rdata", e, rdata);
    endtask
    task sett(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task test_done;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge mclk);
        rst_b <= 1'b1;
        tx_ep <= 4'h1;
        acc(0, `ADDR_ERROR_MASK_HOST, '0, 16'h0000);
        foreach (rows[i]) begin
            acc(1, rows[i].a, rows[i].d, '0);
            acc(0, rows[i].a, '0, rows[i].q);
        end
        sett(2);
        chk("stalled", 16'h0003, ep_stalled);
        chk("handshake", 16'h8003, ep_handshake_on);
        chk("setup", 16'h0000, ep_setup_allow);
        chk("tx", 16'h0001, tx_allowed);
        acc(1, 6'h11, 16'h000C, '0);
        sett(2);
        chk("setup", 16'h0002, ep_setup_allow);
        acc(1, `ADDR_MODE, 16'h0001, '0);
        acc(0, `ADDR_EP_BASE, '0, 16'h00C3);
        chk("slow", 16'h0001, slow_direct_link);
        chk("retry", 16'h0000, nak_retry_on);
        acc(1, `ADDR_EP_BASE, 16'h000C, '0);
        acc(1, `ADDR_ERROR_MASK_HOST, 16'h0010, '0);
        usb_peer_model_inst.errs(8'h02, 1'b0);
        chk("retry", 16'h0001, nak_retry_on);
        acc(0, `ADDR_ERROR_FLAGS_HOST, '0, 16'h0002);
        chk("summary", 16'h0000, summary_error_irq);
        usb_peer_model_inst.errs(8'hFF, 1'b0);
        acc(0, `ADDR_ERROR_FLAGS_HOST, '0, 16'h00FF);
        chk("summary", 16'h0001, summary_error_irq);
        chk("irq", 16'h0000, irq);
        acc(1, `ADDR_IRQ_MASK, 16'h0001, '0);
        sett(3);
        chk("irq", 16'h0001, irq);
        acc(1, `ADDR_ERROR_FLAGS_HOST, 16'h00EF, '0);
        acc(0, `ADDR_ERROR_FLAGS_HOST, '0, 16'h0010);
        acc(1, `ADDR_ERROR_MASK_HOST, 16'h0000, '0);
        sett(2);
        chk("summary", 16'h0000, summary_error_irq);
        acc(1, `ADDR_IRQ_STATUS, 16'h0001, '0);
        sett(3);
        chk("irq", 16'h0000, irq);
        usb_peer_model_inst.pkt(4'h1, 10'h014, 10'h010);
        #1 chk("trunc", 16'h0010, rx_trunc_count);
        acc(0, `ADDR_ERROR_FLAGS_HOST, '0, 16'h0030);
        chk("rx", 16'h0001, rx_allowed);
        acc(1, `ADDR_MODE, 16'h0000, '0);
        acc(1, `ADDR_ERROR_MASK_DEVICE, 16'h0002, '0);
        usb_peer_model_inst.errs(8'h00, 1'b1);
        sett(3);
        chk("summary", 16'h0001, summary_error_irq);
        @(posedge mclk);
        ce <= 1'b0;
        acc(1, 6'h12, 16'h0004, '0);
        @(posedge mclk);
        ce <= 1'b1;
        acc(0, 6'h12, '0, 16'h0000);
        @(posedge mclk);
        rst_b <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_b <= 1'b1;
        acc(0, 6'h11, '0, 16'h0000);
        chk("summary", 16'h0000, summary_error_irq);
        test_done;
    end
    initial begin
        repeat (5000) @(posedge mclk);
        err_total++;
        test_done;
    end
endmodule // tb
